// ### tb/cpc_far_side.sv
// far side of the unit: loadable timer that counts while run is high, and the pin's outside end
// assumes the bench steers load, run and the outside pin level
`timescale 1ns/1ps
module cpc_far_side (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bench control
  input wire logic run,
  input wire logic ld,
  input wire logic [15:0] ld_val,
  input wire logic ext_level,
  // unit side
  input wire logic timer_reset,
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic [15:0] count,
  output logic pin_in
);
  // ==========================================
  // timer
  // special event clears count
  always_ff @(posedge mclk) begin
    if (rst || timer_reset) count <= 16'h0000;
    else if (ld) count <= ld_val;
    else if (run) count <= count + 16'h0001;
  end
  // unit wins the wire while it drives
  assign pin_in = pin_oe ? pin_out : ext_level;
endmodule // cpc_far_side

// ### tb/test_capture_compare_pwm_control.sv
// self-checking bench for the capture/compare/pwm unit
// assumes cpc_far_side models timer and pin; bench is axi4-lite master
`timescale 1ns/1ps
`include "cpc_consts.svh"
module test_capture_compare_pwm_control;
  typedef struct {logic [3:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} cpc_row_t;
  localparam logic [3:0] CT = `CPC_OFF_CTRL;
  localparam logic [3:0] VA = `CPC_OFF_VALUE;
  localparam logic [3:0] ST = `CPC_OFF_STAT;
  localparam logic [3:0] MK = `CPC_OFF_MASK;
  logic mclk, rst, run, ld, ext_level, pre;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [15:0] timer_one_count, ld_val;
  logic timer_reset, adc_start, unit_pin_in, unit_pin_out, unit_pin_oe, irq;
  int n_fail = 0, samples_checked = 0, tr_n = 0, ad_n = 0, k, need;
  logic [3:0] cmp_m[5] = '{4'h2, 4'h8, 4'h9, 4'ha, 4'hb};
  cpc_row_t rows[5] = '{
    '{CT, 32'hffff_ffff, 32'h0000_003f, `CPC_RESP_OKAY},
    '{CT, 32'h0000_0030, 32'h0000_0030, `CPC_RESP_OKAY},
    '{VA, 32'h1234_abcd, 32'h0000_abcd, `CPC_RESP_OKAY},
    '{MK, 32'h0000_00ff, 32'h0000_0001, `CPC_RESP_OKAY},
    '{4'h2, 32'h0000_005a, 32'h0000_0000, `CPC_RESP_SLVERR}};

  cpc_unit #(.SECOND_UNIT(1'b1)) DUT (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .timer_one_count, .timer_reset, .adc_start, .unit_pin_in, .unit_pin_out,
    .unit_pin_oe, .irq);
  cpc_far_side far (.mclk, .rst, .run, .ld, .ld_val, .ext_level, .timer_reset,
    .pin_out(unit_pin_out), .pin_oe(unit_pin_oe), .count(timer_one_count),
    .pin_in(unit_pin_in));

  // ==========================================
  // clock, pulse counters
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    tr_n <= tr_n + (timer_reset === 1'b1);
    ad_n <= ad_n + (adc_start === 1'b1);
  end

  // ==========================================
  // checking and bus tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    forever begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    forever begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        {q, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        break;
      end
    end
    chk(q, e);
  endtask
  task automatic tmr(input logic [15:0] v, input logic go);
    @(posedge mclk);
    {ld, ld_val, run} <= {1'b1, v, go};
    @(posedge mclk);
    ld <= 1'b0;
  endtask
  task automatic pulse;
    @(posedge mclk);
    ext_level <= 1'b1;
    repeat (6) @(posedge mclk);
    ext_level <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
  task automatic tally_and_finish;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // hang guard, well beyond the longest expected run
  initial begin
    repeat (30000) @(posedge mclk);
    n_fail++;
    tally_and_finish();
  end

  // ==========================================
  // main sequence
  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {run, ld, ld_val, ext_level} = '0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    rdc(CT, 32'h0);
    chk(irq, 1'b0);
    foreach (rows[i]) begin
      axi_wr(rows[i].a, rows[i].d);
      chk(r, rows[i].r);
      rdc(rows[i].a, rows[i].q);
      chk(r, rows[i].r);
    end
    axi_wr(CT, 32'h0);
    axi_wr(VA, 32'h40);
    $display("register rows done");
    foreach (cmp_m[i]) begin
      tmr(16'h0030, 1'b0);
      axi_wr(CT, {28'h0, cmp_m[i]});
      repeat (3) @(posedge mclk);
      pre = unit_pin_out;
      k = tr_n;
      chk(unit_pin_oe, cmp_m[i] < 4'ha);
      if (cmp_m[i] inside {4'h8, 4'h9}) chk(pre, cmp_m[i][0]);
      run <= 1'b1;
      for (need = 0; need < 100 && irq !== 1'b1; need++) @(posedge mclk);
      run <= 1'b0;
      repeat (2) @(posedge mclk);
      chk(irq, 1'b1);
      if (cmp_m[i] < 4'ha) chk(unit_pin_out, !pre);
      chk(tr_n - k, cmp_m[i] == 4'hb);
      chk(ad_n, tr_n);
      if (cmp_m[i] == 4'hb) chk(timer_one_count, 16'h0000);
      if (cmp_m[i] == 4'ha) begin
        axi_wr(MK, 32'h0);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        axi_wr(MK, 32'h1);
      end
      rdc(ST, 32'h1);
      axi_wr(ST, 32'h1);
      rdc(ST, 32'h0);
      axi_wr(CT, 32'h0);
      repeat (2) @(posedge mclk);
      chk({unit_pin_oe, unit_pin_out}, 2'b00);
    end
    $display("compare modes done");
    for (k = 4; k < 8; k++) begin
      need = (k == 6) ? 4 : (k == 7) ? 16 : 1;
      axi_wr(ST, 32'h1);
      tmr(16'h0100 + k[15:0], 1'b0);
      axi_wr(CT, {28'h0, k[3:0]});
      repeat (need - 1) pulse();
      ext_level <= 1'b1;
      repeat (6) @(posedge mclk);
      rdc(ST, k != 4);
      ext_level <= 1'b0;
      repeat (6) @(posedge mclk);
      rdc(ST, 32'h1);
      rdc(VA, 32'h0100 + k);
      axi_wr(CT, 32'h0);
    end
    $display("capture modes done");
    axi_wr(ST, 32'h1);
    axi_wr(VA, 32'h02);
    tmr(16'h0000, 1'b1);
    // duty = {8'h02, 2'b01} = 9 counts of 1024
    for (need = 12; need < 16; need++) begin
      axi_wr(CT, 32'h10 + need);
      repeat (1100) @(posedge mclk);
      k = 0;
      repeat (1024) begin
        @(posedge mclk);
        k += (unit_pin_out === 1'b1);
      end
      chk(k, 9);
      axi_wr(CT, 32'h0);
    end
    rdc(ST, 32'h0);
    $display("pwm modes done");
    axi_wr(CT, 32'h08);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    chk({unit_pin_oe, irq}, 2'b00);
    rdc(CT, 32'h0);
    $display("second reset done");
    tally_and_finish();
  end
endmodule // test_capture_compare_pwm_control

// ### verilog/cpc_axil_slave.sv
// axi4-lite slave: one write and one read at a time
// assumes a register file answering rd_data combinationally
`timescale 1ns/1ps
`include "cpc_consts.svh"
module cpc_axil_slave (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // write address and data
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read channels
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // register file side
  output logic wr_en,
  output logic [3:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic [3:0] rd_addr,
  input wire logic [31:0] rd_data
);
  cpc_pkg::cpc_slave_t s_r;
  cpc_pkg::cpc_slave_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.wr_en = 1'b0;
    if (awvalid && s_r.awrdy) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.waddr = awaddr;
    end
    if (wvalid && s_r.wrdy) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = wdata;
      s_nxt.wstrb = wstrb;
    end
    // both halves held: commit and answer together
    if (s_r.aw_got && s_r.w_got) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.wr_en = cpc_pkg::cpc_addr_ok(s_r.waddr);
      s_nxt.bresp = cpc_pkg::cpc_addr_ok(s_r.waddr) ? `CPC_RESP_OKAY : `CPC_RESP_SLVERR;
    end
    if (s_r.bvalid && bready) begin
      s_nxt.bvalid = 1'b0;
    end
    s_nxt.awrdy = ~s_nxt.aw_got & ~s_nxt.bvalid;
    s_nxt.wrdy = ~s_nxt.w_got & ~s_nxt.bvalid;
    if (arvalid && s_r.arrdy) begin
      s_nxt.rd_pend = 1'b1;
      s_nxt.raddr = araddr;
    end
    if (s_r.rd_pend) begin
      s_nxt.rd_pend = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = cpc_pkg::cpc_addr_ok(s_r.raddr) ? rd_data : 32'h0;
      s_nxt.rresp = cpc_pkg::cpc_addr_ok(s_r.raddr) ? `CPC_RESP_OKAY : `CPC_RESP_SLVERR;
    end
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
    end
    s_nxt.arrdy = ~s_nxt.rd_pend & ~s_nxt.rvalid;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready = s_r.awrdy;
  assign wready = s_r.wrdy;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = s_r.arrdy;
  assign rvalid = s_r.rvalid;
  assign rdata = s_r.rdata;
  assign rresp = s_r.rresp;
  assign wr_en = s_r.wr_en;
  assign wr_addr = s_r.waddr;
  assign wr_data = s_r.wdata;
  assign wr_strb = s_r.wstrb;
  assign rd_addr = s_r.raddr;
endmodule // cpc_axil_slave

// ### verilog/cpc_consts.svh
// constants for the capture/compare/pwm unit: offsets, fields, counts
// assumes nothing; included by the package and the design modules
`ifndef CPC_CONSTS_SVH
`define CPC_CONSTS_SVH
// ==========================================
// register byte offsets on the axi4-lite bus
`define CPC_ADDR_W 4
`define CPC_OFF_CTRL 4'h0
`define CPC_OFF_VALUE 4'h4
`define CPC_OFF_STAT 4'h8
`define CPC_OFF_MASK 4'hc
// ==========================================
// control register fields and reset value
`define CPC_MODE_MSB 3
`define CPC_MODE_LSB 0
`define CPC_DLOW_MSB 5
`define CPC_DLOW_LSB 4
`define CPC_CTRL_RST 6'h00
// ==========================================
// capture prescaler, pwm counter, bus answers
`define CPC_PRE4_LAST 4'h3
`define CPC_PRE16_LAST 4'hf
`define CPC_PWM_MSB 9
`define CPC_PERIOD_START 10'h000
`define CPC_RESP_OKAY 2'h0
`define CPC_RESP_SLVERR 2'h2
`endif

// ### verilog/cpc_pin_sync.sv
// two-flop synchroniser for the unit pin with edge pulses
// assumes the pin is asynchronous to mclk
`timescale 1ns/1ps
module cpc_pin_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pin and edges
  input wire logic pin_async,
  output logic rise,
  output logic fall
);
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;

  // only sh_r[1] and sh_r[2] feed the edge gates
  always_comb begin
    sh_nxt = {sh_r[1:0], pin_async};
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sh_r <= 3'h0;
    end else begin
      sh_r <= sh_nxt;
    end
  end

  assign rise = sh_r[1] & ~sh_r[2];
  assign fall = ~sh_r[1] & sh_r[2];
endmodule // cpc_pin_sync

// ### verilog/cpc_pkg.sv
// types and shared functions of the capture/compare/pwm unit
// assumes cpc_consts.svh is on the include path
`include "cpc_consts.svh"
package cpc_pkg;
  // ==========================================
  // mode codes; 0001, 0011 are reserved, 11xx is pwm
  typedef enum logic [3:0] {
    CPC_OFF = 4'h0,
    CPC_TOGGLE = 4'h2,
    CPC_CAP_FALL = 4'h4,
    CPC_CAP_RISE = 4'h5,
    CPC_CAP_4 = 4'h6,
    CPC_CAP_16 = 4'h7,
    CPC_CMP_HIGH = 4'h8,
    CPC_CMP_LOW = 4'h9,
    CPC_CMP_SOFT = 4'ha,
    CPC_CMP_SPECIAL = 4'hb
  } cpc_mode_t;
  // ==========================================
  // state of the core and of the bus slave
  typedef struct packed {
    logic [5:0] ctrl;
    logic [15:0] value;
    logic flag;
    logic mask;
    logic [3:0] mode_q;
    logic [3:0] pre_cnt;
    logic match_q;
    logic [9:0] duty_act;
    logic pin;
    logic pin_oe;
    logic tmr_rst;
    logic adc_go;
    logic irq;
  } cpc_core_t;
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [3:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wr_en;
    logic bvalid;
    logic [1:0] bresp;
    logic rd_pend;
    logic [3:0] raddr;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic awrdy;
    logic wrdy;
    logic arrdy;
  } cpc_slave_t;
  // ==========================================
  function automatic logic cpc_addr_ok(input logic [3:0] a);
    return (a == `CPC_OFF_CTRL) || (a == `CPC_OFF_VALUE) ||
           (a == `CPC_OFF_STAT) || (a == `CPC_OFF_MASK);
  endfunction
  function automatic logic cpc_is_pwm(input logic [3:0] m);
    return m[3] & m[2];
  endfunction
  function automatic logic cpc_is_cap(input logic [3:0] m);
    return ~m[3] & m[2];
  endfunction
endpackage

// ### verilog/cpc_unit.sv
// capture/compare/pwm unit: control register, 16-bit value register,
// event flag with mask and interrupt, pin and timer-side pulses.
// assumes timer_one_count runs on mclk; the pin is asynchronous.
// What this block does
// [R1] one 16-bit register acts as capture latch, compare value or pwm duty
// [R2] control bits 7-6 are unimplemented and read back as zero
// [R3] modes 11xx are pwm; duty is ten bits from value low byte and control bits 5-4
// [R4] mode 0000 disables the unit and returns pin, prescaler and duty state to reset; flag and value are kept
// [R5] mode 0010 toggles the pin on compare match and sets the flag
// [R6] capture on falling, rising, every fourth or every sixteenth rising edge
// [R7] mode 1000 drives pin low on entry, high on match, sets flag
// [R8] mode 1001 drives pin high on entry, low on match, sets flag
// [R9] mode 1010 only sets the flag on match, pin stays port-controlled
// [R10] mode 1011 sets flag, resets timer; second unit also starts conversion
// [R11] a capture sets the event flag, which stays until software clears it
// [R12] control register clears to zero on reset
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "cpc_consts.svh"
module cpc_unit #(
  parameter bit SECOND_UNIT = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // axi4-lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // timer side
  input wire logic [15:0] timer_one_count,
  output logic timer_reset,
  output logic adc_start,
  // unit pin
  input wire logic unit_pin_in,
  output logic unit_pin_out,
  output logic unit_pin_oe,
  // interrupt
  output logic irq
);
  // ==========================================
  // bus slave and pin synchroniser
  logic wr_en;
  logic [3:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [3:0] rd_addr;
  logic [31:0] rd_data;
  logic pin_rise;
  logic pin_fall;

  cpc_axil_slave u_bus (
    .mclk(mclk),
    .rst(rst),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  cpc_pin_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_async(unit_pin_in),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // ==========================================
  // state and decoded events
  cpc_pkg::cpc_core_t s_r;
  cpc_pkg::cpc_core_t s_nxt;
  logic [3:0] mode;
  logic stable;
  logic match_ev;
  logic cap_ev;
  logic cmp_mode;
  logic period_start;
  logic [9:0] duty_new;
  logic wr_ctrl;
  logic wr_value;
  logic wr_stat;
  logic wr_mask;
  logic tmr_eq;

  assign mode = s_r.ctrl[`CPC_MODE_MSB:`CPC_MODE_LSB];
  // one cycle of entry handling after every mode change
  assign stable = (mode == s_r.mode_q);
  assign cmp_mode = (mode == cpc_pkg::CPC_TOGGLE) || (mode[3:2] == 2'h2);
  // one comparator feeds both the event and the dwell memory
  assign tmr_eq = (timer_one_count == s_r.value);
  // match counts once per arrival, not while the timer dwells on it
  assign match_ev = stable && cmp_mode && tmr_eq && !s_r.match_q;
  // [R3] ten-bit duty
  assign duty_new = {s_r.value[7:0], s_r.ctrl[`CPC_DLOW_MSB:`CPC_DLOW_LSB]};
  assign period_start = (timer_one_count[`CPC_PWM_MSB:0] == `CPC_PERIOD_START);
  assign wr_ctrl = wr_en && (wr_addr == `CPC_OFF_CTRL) && wr_strb[0];
  assign wr_value = wr_en && (wr_addr == `CPC_OFF_VALUE);
  assign wr_stat = wr_en && (wr_addr == `CPC_OFF_STAT) && wr_strb[0];
  assign wr_mask = wr_en && (wr_addr == `CPC_OFF_MASK) && wr_strb[0];

  // [R6] capture edge choice
  always_comb begin
    cap_ev = 1'b0;
    if (stable) begin
      unique case (mode)
        cpc_pkg::CPC_CAP_FALL: cap_ev = pin_fall;
        cpc_pkg::CPC_CAP_RISE: cap_ev = pin_rise;
        cpc_pkg::CPC_CAP_4: cap_ev = pin_rise && (s_r.pre_cnt == `CPC_PRE4_LAST);
        cpc_pkg::CPC_CAP_16: cap_ev = pin_rise && (s_r.pre_cnt == `CPC_PRE16_LAST);
        default: cap_ev = 1'b0;
      endcase
    end
  end

  // ==========================================
  // register reads
  always_comb begin
    rd_data = 32'h0;
    unique case (rd_addr)
      // [R2] top control bits zero
      `CPC_OFF_CTRL: rd_data = {26'h0, s_r.ctrl};
      `CPC_OFF_VALUE: rd_data = {16'h0, s_r.value};
      `CPC_OFF_STAT: rd_data = {31'h0, s_r.flag};
      `CPC_OFF_MASK: rd_data = {31'h0, s_r.mask};
      default: rd_data = 32'h0;
    endcase
  end

  // ==========================================
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.tmr_rst = 1'b0;
    s_nxt.adc_go = 1'b0;
    s_nxt.mode_q = mode;
    s_nxt.match_q = tmr_eq;
    // [R2] bits 7-6 not stored
    if (wr_ctrl) begin
      s_nxt.ctrl = wr_data[5:0];
    end
    // [R1] software load of the shared register
    if (wr_value && wr_strb[0]) begin
      s_nxt.value[7:0] = wr_data[7:0];
    end
    if (wr_value && wr_strb[1]) begin
      s_nxt.value[15:8] = wr_data[15:8];
    end
    if (wr_mask) begin
      s_nxt.mask = wr_data[0];
    end
    // write one to clear
    if (wr_stat && wr_data[0]) begin
      s_nxt.flag = 1'b0;
    end
    // prescaler steps on rising edges in the divided capture modes
    if (stable && pin_rise && (mode == cpc_pkg::CPC_CAP_4 || mode == cpc_pkg::CPC_CAP_16)) begin
      s_nxt.pre_cnt = cap_ev ? 4'h0 : s_r.pre_cnt + 4'h1;
    end
    if (!stable) begin
      s_nxt.pre_cnt = 4'h0;
    end
    // [R11] capture latches timer, flag set wins over clear
    if (cap_ev) begin
      s_nxt.value = timer_one_count;
      s_nxt.flag = 1'b1;
    end
    // [R9] any compare match sets the flag
    if (match_ev) begin
      s_nxt.flag = 1'b1;
    end
    unique case (mode)
      // [R4] disabled, back to reset
      cpc_pkg::CPC_OFF: begin
        s_nxt.pre_cnt = 4'h0;
        s_nxt.match_q = 1'b0;
        s_nxt.duty_act = 10'h000;
        s_nxt.pin = 1'b0;
        s_nxt.pin_oe = 1'b0;
      end
      // [R5] toggle on match
      cpc_pkg::CPC_TOGGLE: begin
        s_nxt.pin_oe = 1'b1;
        if (match_ev) begin
          s_nxt.pin = ~s_r.pin;
        end
      end
      // [R7] low on entry, high on match
      cpc_pkg::CPC_CMP_HIGH: begin
        s_nxt.pin_oe = 1'b1;
        if (!stable) begin
          s_nxt.pin = 1'b0;
        end else if (match_ev) begin
          s_nxt.pin = 1'b1;
        end
      end
      // [R8] high on entry, low on match
      cpc_pkg::CPC_CMP_LOW: begin
        s_nxt.pin_oe = 1'b1;
        if (!stable) begin
          s_nxt.pin = 1'b1;
        end else if (match_ev) begin
          s_nxt.pin = 1'b0;
        end
      end
      // [R10] special event pulses
      cpc_pkg::CPC_CMP_SPECIAL: begin
        s_nxt.pin = 1'b0;
        s_nxt.pin_oe = 1'b0;
        s_nxt.tmr_rst = match_ev;
        s_nxt.adc_go = match_ev && SECOND_UNIT;
      end
      default: begin
        s_nxt.pin = 1'b0;
        s_nxt.pin_oe = 1'b0;
        // [R3] pwm; duty only picked up at period start to avoid glitches
        if (cpc_pkg::cpc_is_pwm(mode)) begin
          s_nxt.pin_oe = 1'b1;
          if (period_start) begin
            s_nxt.duty_act = duty_new;
          end
          s_nxt.pin = timer_one_count[`CPC_PWM_MSB:0] < s_nxt.duty_act;
        end
      end
    endcase
    s_nxt.irq = s_nxt.flag & s_nxt.mask;
  end

  // [R12] control cleared on reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign timer_reset = s_r.tmr_rst;
  assign adc_start = s_r.adc_go;
  assign unit_pin_out = s_r.pin;
  assign unit_pin_oe = s_r.pin_oe;
  assign irq = s_r.irq;

  // ==========================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_CTRL_TOP_ZERO: assert property ( // [R2]
    (wr_ctrl |=> s_r.ctrl == $past(wr_data[5:0]))
      and (s_axi_rvalid && rd_addr == `CPC_OFF_CTRL |-> s_axi_rdata[31:6] == 26'h0))
    else $error("control top bits not zero");
  AST_PWM_DUTY: assert property ( // [R3]
    cpc_pkg::cpc_is_pwm(mode) && stable && !period_start && !wr_ctrl
      |=> unit_pin_out == ($past(timer_one_count[`CPC_PWM_MSB:0]) < $past(s_r.duty_act)))
    else $error("pwm level wrong");
  AST_OFF_RESET: assert property ( // [R4]
    mode == cpc_pkg::CPC_OFF |=> !unit_pin_oe && !unit_pin_out && s_r.pre_cnt == 4'h0)
    else $error("disabled unit not cleared");
  AST_TOGGLE: assert property ( // [R5]
    mode == cpc_pkg::CPC_TOGGLE && match_ev
      |=> unit_pin_out != $past(unit_pin_out) && s_r.flag)
    else $error("toggle on match missing");
  AST_CAPTURE: assert property ( // [R6]
    cap_ev |=> s_r.value == $past(timer_one_count) && s_r.flag)
    else $error("capture did not latch timer");
  AST_ENTRY_LOW: assert property ( // [R7]
    mode == cpc_pkg::CPC_CMP_HIGH && !stable |=> !unit_pin_out && unit_pin_oe)
    else $error("entry level not low");
  AST_MATCH_HIGH: assert property ( // [R7]
    mode == cpc_pkg::CPC_CMP_HIGH && match_ev && !wr_ctrl |=> unit_pin_out ##1 unit_pin_out)
    else $error("pin not forced high");
  AST_MATCH_LOW: assert property ( // [R8]
    mode == cpc_pkg::CPC_CMP_LOW && match_ev && !wr_ctrl |=> !unit_pin_out && s_r.flag)
    else $error("pin not forced low");
  AST_SOFT_ONLY: assert property ( // [R9]
    mode == cpc_pkg::CPC_CMP_SOFT && match_ev |=> !unit_pin_oe && s_r.flag)
    else $error("soft compare touched pin");
  AST_SPECIAL: assert property ( // [R10]
    mode == cpc_pkg::CPC_CMP_SPECIAL && match_ev
      |=> timer_reset && (adc_start == SECOND_UNIT) ##1 !timer_reset)
    else $error("special event pulse wrong");
  AST_FLAG_STICKY: assert property ( // [R11]
    s_r.flag && !(wr_stat && wr_data[0]) |=> s_r.flag)
    else $error("flag dropped without clear");
  AST_RESET_CTRL: assert property ( // [R12]
    $past(rst) |-> s_r.ctrl == `CPC_CTRL_RST && !unit_pin_oe)
    else $error("control not zero after reset");
  AST_IRQ: assert property (
    irq == (s_r.flag && s_r.mask))
    else $error("interrupt level wrong");
  // guards on entry levels, pulses and the shared register
  AST_ENTRY_HIGH: assert property ( // [R8]
    mode == cpc_pkg::CPC_CMP_LOW && !stable |=> unit_pin_out && unit_pin_oe)
    else $error("entry level not high");
  AST_CAP_PIN_FREE: assert property ( // [R6]
    cpc_pkg::cpc_is_cap(mode) |=> !unit_pin_oe)
    else $error("capture mode drives pin");
  AST_PRESCALE: assert property ( // [R6]
    mode == cpc_pkg::CPC_CAP_4 && stable |-> s_r.pre_cnt <= `CPC_PRE4_LAST)
    else $error("prescaler past fourth edge");
  AST_DUTY_LATCH: assert property ( // [R3]
    cpc_pkg::cpc_is_pwm(mode) && period_start |=> s_r.duty_act == $past(duty_new))
    else $error("duty not taken at period start");
  AST_ADC_WITH_RESET: assert property ( // [R10]
    adc_start |-> SECOND_UNIT && timer_reset)
    else $error("conversion start without special event");
  AST_TMR_RST_PULSE: assert property ( // [R10]
    timer_reset |=> !timer_reset)
    else $error("timer reset longer than one cycle");
  AST_FLAG_CLEAR: assert property ( // [R11]
    wr_stat && wr_data[0] && !cap_ev && !match_ev |=> !s_r.flag)
    else $error("flag not cleared by software");
  AST_VALUE_HOLD: assert property ( // [R1]
    cmp_mode && !wr_value |=> s_r.value == $past(s_r.value))
    else $error("compare value changed by itself");
  AST_OFF_QUIET: assert property ( // [R4]
    mode == cpc_pkg::CPC_OFF |=> !timer_reset && !adc_start)
    else $error("disabled unit pulsed timer side");

  COV_CAPTURE16: cover property (mode == cpc_pkg::CPC_CAP_16 && cap_ev);
  COV_TOGGLE: cover property (mode == cpc_pkg::CPC_TOGGLE && match_ev);
  COV_PWM: cover property (cpc_pkg::cpc_is_pwm(mode) && period_start ##1 unit_pin_out);
  COV_SPECIAL: cover property (timer_reset);
  COV_CAPTURE_FALL: cover property (mode == cpc_pkg::CPC_CAP_FALL && cap_ev);
endmodule // cpc_unit
